// [logic/svo_pkg.sv]
// servo connector output signals and safe-stop inputs: shared constants and types
// assumes one 50 MHz clock and a plain strobe register port with 8-bit byte addresses
package svo_pkg;
   localparam int SVO_AW = 8;
   localparam logic [7:0] SVO_CTRL_OFS = 8'h00;
   localparam logic [7:0] SVO_OMAP_OFS = 8'h04;
   localparam logic [7:0] SVO_IMAP_OFS = 8'h08;
   localparam logic [7:0] SVO_STAT_OFS = 8'h0C;
   localparam logic [7:0] SVO_MASK_OFS = 8'h10;
   localparam logic [7:0] SVO_LIVE_OFS = 8'h14;
   localparam int SVO_CTRL_SPARE1_BIT = 0;
   localparam int SVO_NFUNC = 8;
   localparam int SVO_OMAP_W = 2;
   localparam int SVO_NIN = 6;
   localparam int SVO_IMAP_W = 3;
   localparam int SVO_NEV = 4;
   localparam int SVO_EV_FAULT = 0;
   localparam int SVO_EV_BB_ON = 1;
   localparam int SVO_EV_BB_OFF = 2;
   localparam int SVO_EV_INDEX = 3;
   localparam logic [1:0] SVO_PAIR_NONE = 2'h0;
   localparam logic [1:0] SVO_PAIR_1 = 2'h1;
   localparam logic [1:0] SVO_PAIR_2 = 2'h2;
   localparam logic [1:0] SVO_PAIR_3 = 2'h3;
   localparam logic [2:0] SVO_SEL_ON = 3'h6;
   localparam logic [2:0] SVO_SEL_OFF = 3'h7;
   localparam logic [1:0] SVO_MODE_POS = 2'h0;
   localparam logic [1:0] SVO_MODE_SPD = 2'h1;
   localparam logic [0:0] SVO_CTRL_RST = 1'h0;
   localparam logic [15:0] SVO_OMAP_RST = 16'h0000;
   // factory routing: each function on its own pin, in pin order
   localparam logic [17:0] SVO_IMAP_RST = 18'h2_C688;
   localparam logic [3:0] SVO_MASK_RST = 4'h0;
   typedef enum logic [3:0] {
      SVO_Q00 = 4'h1,
      SVO_Q10 = 4'h2,
      SVO_Q11 = 4'h4,
      SVO_Q01 = 4'h8
   } svo_quad_type;
endpackage

// [logic/svo_io.sv]
// servo connector output routing, encoder emulation and safe-stop logic
// assumes all inputs synchronous to clk_sys; pin pairs are driven as single-ended levels
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module svo_io (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [svo_pkg::SVO_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq_out,
   input wire logic fault_in,
   input wire logic lock_release_req,
   input wire logic [1:0] ctrl_mode,
   input wire logic position_done,
   input wire logic speed_match,
   input wire logic rotating,
   input wire logic drive_ready,
   input wire logic torque_clamped,
   input wire logic speed_clamped,
   input wire logic caution,
   input wire logic approach_zone,
   input wire logic [5:0] phys_in,
   output logic homing_slowdown_in,
   output logic forward_limit_in,
   output logic reverse_limit_in,
   output logic latch_trigger_1,
   output logic latch_trigger_2,
   output logic latch_trigger_3,
   input wire logic enc_step,
   input wire logic enc_dir,
   input wire logic enc_index,
   output logic quad_a_out,
   output logic quad_a_out_n,
   output logic quad_b_out,
   output logic quad_b_out_n,
   output logic index_pulse_out,
   output logic index_pulse_out_n,
   output logic fault_indicator_out,
   output logic holding_lock_release_out,
   output logic spare_output_2,
   output logic spare_output_3,
   input wire logic safe_stop_in_1,
   input wire logic safe_stop_in_2,
   output logic motor_current_cut,
   output logic stop_monitor_out
);
   import svo_pkg::*;

   // OR of every valid function routed to one pair
   function automatic logic pair_or(input logic [15:0] map, input logic [7:0] fn,
                                    input logic [1:0] pair);
      logic acc;
      acc = 1'b0;
      for (int i = 0; i < SVO_NFUNC; i++) begin
         if (map[i*SVO_OMAP_W +: SVO_OMAP_W] == pair) begin
            acc = acc | fn[i];
         end
      end
      return acc;
   endfunction

   // pin select: 0..5 a physical pin, then fixed on and fixed off
   function automatic logic in_sel(input logic [5:0] pins, input logic [2:0] sel);
      logic v;
      case (sel)
         SVO_SEL_ON: v = 1'b1;
         SVO_SEL_OFF: v = 1'b0;
         default: v = pins[sel];
      endcase
      return v;
   endfunction

   logic [0:0] ctrl_reg, ctrl_next;
   logic [15:0] omap_reg, omap_next;
   logic [17:0] imap_reg, imap_next;
   logic [3:0] stat_reg, stat_next;
   logic [3:0] mask_reg, mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [3:0] ev;
   logic [31:0] live;

   logic [7:0] fn_valid;
   logic [5:0] lin_reg, lin_next;
   logic fault_ind_reg, fault_ind_next;
   logic lock_reg, lock_next;
   logic sp2_reg, sp2_next;
   logic sp3_reg, sp3_next;
   logic bb_reg, bb_next;
   logic mon_reg, mon_next;
   logic idx_reg, idx_next;
   svo_quad_type quad_reg, quad_next;

   // mode gating: unmeasured functions read as inactive
   always_comb begin
      fn_valid[0] = position_done & (ctrl_mode == SVO_MODE_POS);
      fn_valid[1] = speed_match & (ctrl_mode == SVO_MODE_SPD);
      fn_valid[2] = rotating;
      fn_valid[3] = drive_ready;
      fn_valid[4] = torque_clamped;
      fn_valid[5] = speed_clamped;
      fn_valid[6] = caution;
      fn_valid[7] = approach_zone & (ctrl_mode == SVO_MODE_POS);
   end

   // input function routing
   generate
      for (genvar g = 0; g < SVO_NIN; g++) begin : g_in
         assign lin_next[g] = in_sel(phys_in, imap_reg[g*SVO_IMAP_W +: SVO_IMAP_W]);
      end
   endgenerate

   // safe-stop path uses only the two inputs, never a configuration register
   always_comb begin
      fault_ind_next = ~fault_in;
      bb_next = ~safe_stop_in_1 | ~safe_stop_in_2;
      mon_next = ~safe_stop_in_1 & ~safe_stop_in_2 & bb_reg;
      // pair 1 is the lock release unless handed to spare 1
      if (ctrl_reg[SVO_CTRL_SPARE1_BIT]) begin
         lock_next = pair_or(omap_reg, fn_valid, SVO_PAIR_1);
      end else begin
         lock_next = lock_release_req | pair_or(omap_reg, fn_valid, SVO_PAIR_1);
      end
      sp2_next = pair_or(omap_reg, fn_valid, SVO_PAIR_2);
      sp3_next = pair_or(omap_reg, fn_valid, SVO_PAIR_3);
      idx_next = enc_index;
   end

   // quadrature walk: forward gives A leading B by a quarter period
   always_comb begin
      quad_next = quad_reg;
      if (enc_step) begin
         case (quad_reg)
            SVO_Q00: quad_next = enc_dir ? SVO_Q10 : SVO_Q01;
            SVO_Q10: quad_next = enc_dir ? SVO_Q11 : SVO_Q00;
            SVO_Q11: quad_next = enc_dir ? SVO_Q01 : SVO_Q10;
            SVO_Q01: quad_next = enc_dir ? SVO_Q00 : SVO_Q11;
            default: quad_next = SVO_Q00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lin_reg <= 6'h00;
         fault_ind_reg <= 1'b0;
         lock_reg <= 1'b0;
         sp2_reg <= 1'b0;
         sp3_reg <= 1'b0;
         bb_reg <= 1'b1;
         mon_reg <= 1'b0;
         idx_reg <= 1'b0;
         quad_reg <= SVO_Q00;
      end else if (ce) begin
         lin_reg <= lin_next;
         fault_ind_reg <= fault_ind_next;
         lock_reg <= lock_next;
         sp2_reg <= sp2_next;
         sp3_reg <= sp3_next;
         bb_reg <= bb_next;
         mon_reg <= mon_next;
         idx_reg <= idx_next;
         quad_reg <= quad_next;
      end
   end

   // events, status and register port
   always_comb begin
      ev = 4'h0;
      ev[SVO_EV_FAULT] = fault_in & fault_ind_reg;
      ev[SVO_EV_BB_ON] = bb_next & ~bb_reg;
      ev[SVO_EV_BB_OFF] = ~bb_next & bb_reg;
      ev[SVO_EV_INDEX] = enc_index & ~idx_reg;
      live = {26'h000_0000, mon_reg, bb_reg, idx_reg, lock_reg, fault_ind_reg, ctrl_mode[0]};
      ctrl_next = ctrl_reg;
      omap_next = omap_reg;
      imap_next = imap_reg;
      mask_next = mask_reg;
      stat_next = stat_reg;
      rdata_next = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            SVO_CTRL_OFS: ctrl_next = reg_wdata[0:0];
            SVO_OMAP_OFS: omap_next = reg_wdata[15:0];
            SVO_IMAP_OFS: imap_next = reg_wdata[17:0];
            SVO_MASK_OFS: mask_next = reg_wdata[3:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            SVO_CTRL_OFS: rdata_next = {31'h0000_0000, ctrl_reg};
            SVO_OMAP_OFS: rdata_next = {16'h0000, omap_reg};
            SVO_IMAP_OFS: rdata_next = {14'h0000, imap_reg};
            SVO_STAT_OFS: rdata_next = {28'h000_0000, stat_reg};
            SVO_MASK_OFS: rdata_next = {28'h000_0000, mask_reg};
            SVO_LIVE_OFS: rdata_next = live;
            default: rdata_next = 32'h0000_0000;
         endcase
         if (reg_addr == SVO_STAT_OFS) begin
            stat_next = 4'h0;
         end
      end
      // a new event in the clearing read cycle survives
      stat_next = stat_next | ev;
   end

   // ce low freezes the port too, so a read then returns stale data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg <= SVO_CTRL_RST;
         omap_reg <= SVO_OMAP_RST;
         imap_reg <= SVO_IMAP_RST;
         stat_reg <= 4'h0;
         mask_reg <= SVO_MASK_RST;
         rdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         omap_reg <= omap_next;
         imap_reg <= imap_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq_out = |(stat_reg & mask_reg);
   // function index j sits on lin_reg[j], homing slowdown first
   assign {reverse_limit_in, forward_limit_in, homing_slowdown_in} = lin_reg[2:0];
   assign {latch_trigger_3, latch_trigger_2, latch_trigger_1} = lin_reg[5:3];
   assign quad_a_out = quad_reg[1] | quad_reg[2];
   assign quad_b_out = quad_reg[2] | quad_reg[3];
   assign quad_a_out_n = ~quad_a_out;
   assign quad_b_out_n = ~quad_b_out;
   assign index_pulse_out = idx_reg;
   assign index_pulse_out_n = ~idx_reg;
   assign fault_indicator_out = fault_ind_reg;
   assign holding_lock_release_out = lock_reg;
   assign spare_output_2 = sp2_reg;
   assign spare_output_3 = sp3_reg;
   assign motor_current_cut = bb_reg;
   assign stop_monitor_out = mon_reg;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence both_off_s;
      ce && !safe_stop_in_1 && !safe_stop_in_2;
   endsequence

   sequence fwd_from_zero_s;
      ce && enc_step && enc_dir && !quad_a_out && !quad_b_out;
   endsequence

   fault_ind_a: assert property (ce |=> fault_indicator_out == !$past(fault_in))
      else $error("fault indicator does not follow fault");
   lock_release_a: assert property (ce && !ctrl_reg[0] && lock_release_req
      |=> holding_lock_release_out)
      else $error("lock not released on request");
   spare_one_a: assert property (ce && ctrl_reg[0] && omap_reg == 16'h0000
      |=> !holding_lock_release_out)
      else $error("spare pair still follows lock request");
   route_or_a: assert property (ce && omap_reg[5:4] == SVO_PAIR_3 && rotating
      |=> spare_output_3)
      else $error("routed function missing on pair");
   spare_idle_a: assert property (ce && omap_reg == 16'h0000
      |=> !spare_output_2 && !spare_output_3)
      else $error("unrouted spare output active");
   quad_step_a: assert property (fwd_from_zero_s |=> quad_a_out && !quad_b_out
      ##0 quad_a_out_n != quad_a_out)
      else $error("quadrature step wrong");
   index_out_a: assert property (ce && enc_index |=> index_pulse_out && !index_pulse_out_n)
      else $error("index pulse missing");
   bb_entry_a: assert property (ce && (!safe_stop_in_1 || !safe_stop_in_2)
      |=> motor_current_cut)
      else $error("baseblock not entered");
   stop_mon_a: assert property (both_off_s ##1 both_off_s |=> stop_monitor_out)
      else $error("stop monitor not on");
   mon_off_a: assert property (ce && safe_stop_in_1 |=> !stop_monitor_out)
      else $error("stop monitor on with input on");
   in_route_a: assert property (ce && imap_reg[2:0] == SVO_SEL_ON |=> homing_slowdown_in)
      else $error("input routing wrong");
   mode_gate_a: assert property (ce && ctrl_mode == SVO_MODE_SPD
      && omap_reg == 16'h0002 |=> !spare_output_2)
      else $error("position done routed in speed mode");
endmodule
`default_nettype wire

// [tb/svo_host_rx.sv]
// host side line receivers: decode the differential encoder outputs and drive safe-stop lines
// assumes the drive's clock and its synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module svo_host_rx (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic a_p,
   input wire logic a_n,
   input wire logic b_p,
   input wire logic b_n,
   input wire logic z_p,
   input wire logic z_n,
   input wire logic [1:0] stop_req,
   output logic safe_1,
   output logic safe_2,
   output logic rx_ok,
   output logic [15:0] count
);
   logic [1:0] idx_reg;
   logic [1:0] idx;
   logic [1:0] dlt;
   // safety gear keeps both lines on unless a stop is commanded
   assign safe_1 = !stop_req[0];
   assign safe_2 = !stop_req[1];
   assign idx = {b_p, a_p ^ b_p};
   assign dlt = idx - idx_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         idx_reg <= 2'h0;
         count <= 16'h0000;
         rx_ok <= 1'b1;
      end else begin
         idx_reg <= idx;
         if (dlt == 2'h1) begin
            count <= count + 16'h0001;
         end
         if (dlt == 2'h3) begin
            count <= count - 16'h0001;
         end
         // a skipped state or equal legs cannot be decoded by a line receiver
         if (dlt == 2'h2 || a_p == a_n || b_p == b_n || z_p == z_n) begin
            rx_ok <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/test_svo_io.sv]
// self-checking bench for the connector output and safe-stop block
// assumes svo_pkg and svo_io compiled first; host receivers model the far side
`timescale 1ns/1ns
`default_nettype none
module test_svo_io;
   import svo_pkg::*;
   logic clk_sys, rst, ce, reg_wr, reg_rd, fault_in, lock_req, st, dr, sp1;
   logic enc_step, enc_dir, enc_index, irq_out, qa, qan, qb, qbn, qz, qzn;
   logic flt, lock, sp2, sp3, s1, s2, cut, mon, rx_ok;
   logic [7:0] reg_addr, fn;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [1:0] ctrl_mode, stop_req;
   logic [5:0] phys_in, rin;
   logic [15:0] cnt, exp_cnt, om;
   logic [17:0] im;
   logic [3:0] p;
   integer n_fail, checks, seed, i;
   svo_io dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_out(irq_out), .fault_in(fault_in), .lock_release_req(lock_req),
      .ctrl_mode(ctrl_mode), .position_done(fn[0]), .speed_match(fn[1]), .rotating(fn[2]),
      .drive_ready(fn[3]), .torque_clamped(fn[4]), .speed_clamped(fn[5]), .caution(fn[6]),
      .approach_zone(fn[7]), .phys_in(phys_in), .homing_slowdown_in(rin[0]),
      .forward_limit_in(rin[1]), .reverse_limit_in(rin[2]), .latch_trigger_1(rin[3]),
      .latch_trigger_2(rin[4]), .latch_trigger_3(rin[5]), .enc_step(enc_step),
      .enc_dir(enc_dir), .enc_index(enc_index), .quad_a_out(qa), .quad_a_out_n(qan),
      .quad_b_out(qb), .quad_b_out_n(qbn), .index_pulse_out(qz), .index_pulse_out_n(qzn),
      .fault_indicator_out(flt), .holding_lock_release_out(lock), .spare_output_2(sp2),
      .spare_output_3(sp3), .safe_stop_in_1(s1), .safe_stop_in_2(s2),
      .motor_current_cut(cut), .stop_monitor_out(mon));
   svo_host_rx host (.clk_sys(clk_sys), .rst(rst), .a_p(qa), .a_n(qan), .b_p(qb), .b_n(qbn),
      .z_p(qz), .z_n(qzn), .stop_req(stop_req), .safe_1(s1), .safe_2(s2), .rx_ok(rx_ok),
      .count(cnt));
   function automatic logic [3:0] exp_pairs(logic [15:0] m, logic [7:0] f, logic [1:0] md,
                                            logic lk, logic s);
      logic [3:0] r;
      logic [7:0] v;
      v = f;
      v[0] = f[0] & (md == SVO_MODE_POS);
      v[7] = f[7] & (md == SVO_MODE_POS);
      v[1] = f[1] & (md == SVO_MODE_SPD);
      r = {3'h0, 1'b0};
      r[1] = lk & !s;
      for (int k = 0; k < 8; k++) begin
         r[m[2*k+:2]] = r[m[2*k+:2]] | v[k];
      end
      return r;
   endfunction
   function automatic logic [5:0] exp_rin(logic [17:0] m, logic [5:0] ph);
      logic [5:0] r;
      logic [2:0] s;
      for (int k = 0; k < 6; k++) begin
         s = m[3*k+:3];
         r[k] = (s < 3'h6) ? ph[s] : (s == SVO_SEL_ON);
      end
      return r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // a hang anywhere counts as a failure
   initial begin
      #2_000_000;
      n_fail++;
      finish_test;
   end
   initial begin
      seed = 32'h0000_d367;
      {n_fail, checks} = 0;
      {rst, ce} = 2'h3;
      {reg_wr, reg_rd, fault_in, lock_req, enc_step, enc_dir, enc_index} = 7'h00;
      {reg_addr, fn, reg_wdata, ctrl_mode, stop_req, phys_in} = 0;
      exp_cnt = 16'h0000;
      tick(2);
      chk("rst_out", 32'h0000_0001, {flt, mon, cut});
      @(posedge clk_sys);
      rst <= 1'b0;
      tick(2);
      rd(SVO_STAT_OFS, d);
      rd(8'hFC, d);
      chk("unmapped", 32'h0000_0000, d);
      wr(SVO_MASK_OFS, 32'h0000_0001);
      @(posedge clk_sys);
      fault_in <= 1'b1;
      tick(1);
      chk("fault_on", 0, flt);
      @(posedge clk_sys);
      fault_in <= 1'b0;
      tick(1);
      chk("fault_off", 32'h0000_0003, {irq_out, flt});
      rd(SVO_STAT_OFS, d);
      chk("stat", 32'h0000_0001, d);
      tick(1);
      chk("irq_clr", 0, irq_out);
      wr(SVO_MASK_OFS, 32'h0000_0000);
      // routing, mode gating and safe-stop combos; the first passes are hand-picked corners
      for (i = 0; i < 40; i++) begin
         om = (i < 2) ? 16'h0000 : (i == 2) ? 16'hAAAA : 16'($random(seed));
         // i == 3 routes position done to pair 2 while in speed mode
         om = (i == 3) ? 16'h0002 : om;
         im = (i == 0) ? SVO_IMAP_RST : 18'($random(seed));
         sp1 = (i < 4) ? (i == 1) : 1'($random(seed));
         wr(SVO_OMAP_OFS, {16'h0000, om});
         wr(SVO_IMAP_OFS, {14'h0000, im});
         wr(SVO_CTRL_OFS, {31'h0000_0000, sp1});
         @(posedge clk_sys);
         fn <= (i == 2) ? 8'h40 : (i == 3) ? 8'h01 : 8'($random(seed));
         ctrl_mode <= (i == 3) ? SVO_MODE_SPD : 2'($random(seed));
         lock_req <= (i < 2) ? i[0] : 1'($random(seed));
         phys_in <= 6'($random(seed));
         stop_req <= (i < 4) ? i[1:0] : 2'($random(seed));
         tick(2);
         p = exp_pairs(om, fn, ctrl_mode, lock_req, sp1);
         chk("pairs", {29'h0, p[3:1]}, {29'h0, sp3, sp2, lock});
         chk("routed", exp_rin(im, phys_in), rin);
         chk("cut", |stop_req, cut);
         chk("monitor", &stop_req, mon);
      end
      rd(SVO_OMAP_OFS, d);
      chk("omap_rd", {16'h0000, om}, d);
      rd(SVO_IMAP_OFS, d);
      chk("imap_rd", {14'h0000, im}, d);
      rd(SVO_CTRL_OFS, d);
      chk("ctrl_rd", {31'h0000_0000, sp1}, d);
      // ce low must freeze the indicator even though a fault appears
      @(posedge clk_sys);
      ce <= 1'b0;
      fault_in <= 1'b1;
      tick(2);
      chk("ce_hold", 1, flt);
      @(posedge clk_sys);
      ce <= 1'b1;
      fault_in <= 1'b0;
      @(posedge clk_sys);
      stop_req <= 2'h0;
      for (i = 0; i < 200; i++) begin
         st = (i < 16) ? 1'b1 : 1'($random(seed));
         dr = (i < 8) ? 1'b1 : (i < 16) ? 1'b0 : 1'($random(seed));
         @(posedge clk_sys);
         enc_step <= st;
         enc_dir <= dr;
         exp_cnt = st ? (dr ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001) : exp_cnt;
      end
      @(posedge clk_sys);
      enc_step <= 1'b0;
      enc_index <= 1'b1;
      tick(2);
      chk("count", exp_cnt, cnt);
      chk("index", 32'h0000_0002, {qz, qzn});
      @(posedge clk_sys);
      enc_index <= 1'b0;
      tick(1);
      chk("index_n", 32'h0000_0001, {qz, qzn});
      rd(SVO_STAT_OFS, d);
      chk("index_ev", 1, d[3]);
      chk("rx_ok", 1, rx_ok);
      finish_test;
   end
endmodule
`default_nettype wire
